// >>> rtl/ivp_consts.vh
// constants for the interrupt vector placement block
// assumes inclusion by bare name from the rtl files
`ifndef IVP_CONSTS_VH
`define IVP_CONSTS_VH

// ****************************************
// register map (byte addresses and control reset value)
// ****************************************
`define MCU_CONTROL_OFFSET 8'h00
`define PLACEMENT_STATUS_OFFSET 8'h04
`define MCU_CONTROL_RESET 8'h00

// ****************************************
// mcu_control field positions
// ****************************************
`define DEBUG_PORT_DISABLE_BIT 7
`define PULLUP_DISABLE_BIT 4
`define VECTOR_SELECT_BIT 1
`define VECTOR_CHANGE_ENABLE_BIT 0

// ****************************************
// placement_status field positions
// ****************************************
`define STAT_RESET_ADDR_LSB 0
`define STAT_BLOCKED_BIT 16
`define STAT_WINDOW_BIT 17
`define STAT_IN_BOOT_BIT 18

// ****************************************
// timing
// ****************************************
`define CHANGE_WINDOW_CYCLES 4

// ****************************************
// vector layout (word addresses and vector numbers)
// ****************************************
`define RESET_VECTOR_ADDR 16'h0000
`define VECTOR_TABLE_BASE 16'h0002
`define VECTOR_SPACING 16'h0002
`define VEC_ANALOG_COMP 5'h1b
`define VEC_EEPROM_READY 5'h1c
`define VEC_PROGRAM_STORE_READY 5'h1d

`endif

// >>> rtl/vector_address_calc.v
// reset address, vector base and one vector address from fuse state
// assumes fuse inputs are stable registered levels; select may be the unregistered next-state level
`timescale 1ns/1ps
`include "ivp_consts.vh"
module vector_address_calc #(
    parameter [15:0] BOOT_START_SZ0 = 16'h3800,
    parameter [15:0] BOOT_START_SZ1 = 16'h3c00,
    parameter [15:0] BOOT_START_SZ2 = 16'h3e00,
    parameter [15:0] BOOT_START_SZ3 = 16'h3f00
) (
    // fuse and select state
    input wire boot_reset_fuse,
    input wire [1:0] boot_size_fuses,
    input wire vector_select,
    // lookup
    input wire [4:0] vector_number,
    // results
    output reg [15:0] boot_start,
    output wire [15:0] reset_address,
    output wire [15:0] vector_base,
    output wire [15:0] vector_address
);

    // ****************************************
    // boot section start
    // ****************************************
    always @* begin
        case (boot_size_fuses)
            2'b00: boot_start = BOOT_START_SZ0;
            2'b01: boot_start = BOOT_START_SZ1;
            2'b10: boot_start = BOOT_START_SZ2;
            default: boot_start = BOOT_START_SZ3;
        endcase
    end

    // ****************************************
    // placement
    // ****************************************
    wire [15:0] table_offset;
    wire [15:0] slot;

    // programmed fuse reads as zero
    assign reset_address = boot_reset_fuse ? `RESET_VECTOR_ADDR :
        boot_start;
    assign vector_base = vector_select ?
        boot_start + `VECTOR_TABLE_BASE : `VECTOR_TABLE_BASE;
    assign slot = (vector_number > 5'h01) ?
        {11'h000, vector_number} - 16'h0002 : 16'h0000;
    assign table_offset = {slot[14:0], 1'b0};
    // vectors 0 and 1 give the reset address, the rest sit two words apart from the base
    assign vector_address = (vector_number <= 5'h01) ? reset_address :
        vector_base + table_offset;

endmodule

// >>> rtl/interrupt_vector_placement.v
// interrupt vector placement with guarded vector select change
// assumes an ahb-lite master, core fetch address and instr_done pulse
`timescale 1ns/1ps
`include "ivp_consts.vh"
module interrupt_vector_placement #(
    parameter NUM_PORTS = 3,
    parameter [15:0] BOOT_START_SZ0 = 16'h3800,
    parameter [15:0] BOOT_START_SZ1 = 16'h3c00,
    parameter [15:0] BOOT_START_SZ2 = 16'h3e00,
    parameter [15:0] BOOT_START_SZ3 = 16'h3f00
) (
    // clock and reset
    input wire clk_sys,
    input wire srst,
    // ahb-lite slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg hreadyout,
    output reg hresp,
    output reg [31:0] hrdata,
    // fuses and lock bits
    input wire boot_reset_fuse,
    input wire [1:0] boot_size_fuses,
    input wire app_side_boot_lock,
    input wire boot_side_boot_lock,
    // core fetch and dispatch
    input wire [15:0] fetch_address,
    input wire instr_done,
    input wire global_int_enable,
    input wire [4:0] lookup_vector,
    input wire analog_comp_req,
    input wire eeprom_ready_event,
    input wire program_store_ready_event,
    // placement results
    output reg [15:0] reset_address,
    output reg [15:0] vector_base,
    output reg [15:0] lookup_address,
    output reg irq_request,
    output reg [4:0] irq_vector,
    output reg [15:0] irq_address,
    output reg irq_blocked,
    // control bits
    output reg vector_select,
    output reg pullup_disable,
    output reg [NUM_PORTS-1:0] port_pullup_off,
    output reg debug_port_disable
);

    // ****************************************
    // state
    // ****************************************
    localparam integer WINDOW_INT = `CHANGE_WINDOW_CYCLES - 1;
    localparam [2:0] WINDOW_LOAD = WINDOW_INT[2:0];

    reg change_enable;
    reg [2:0] window_count;
    reg tail_block;
    reg fuse_boot_reset;
    reg [1:0] fuse_boot_size;
    reg lock_app;
    reg lock_boot;
    reg dp_write;
    reg dp_ctrl;

    reg next_select;
    reg next_change_enable;
    reg [2:0] next_window_count;
    reg next_tail_block;
    reg next_pullup_disable;
    reg next_debug_port_disable;
    reg [4:0] next_irq_vector;
    reg next_req_any;

    wire ap_valid;
    wire ap_ctrl;
    wire ap_stat;
    wire wr_ctrl;
    wire [7:0] wd;
    wire [15:0] boot_start;
    wire [15:0] calc_reset;
    wire [15:0] calc_base;
    wire [15:0] calc_lookup;
    wire [15:0] calc_irq;
    wire in_boot;
    wire lock_block;
    wire next_blocked;
    wire [7:0] ctrl_read;
    wire [31:0] stat_read;

    // ****************************************
    // bus decode
    // ****************************************
    assign ap_valid = hsel & hready & htrans[1];
    assign ap_ctrl = (haddr == {24'h000000, `MCU_CONTROL_OFFSET});
    assign ap_stat = (haddr == {24'h000000, `PLACEMENT_STATUS_OFFSET});
    assign wr_ctrl = dp_write & dp_ctrl;
    assign wd = hwdata[7:0];

    always @(posedge clk_sys) begin
        if (srst) begin
            dp_write <= 1'b0;
            dp_ctrl <= 1'b0;
        end else begin
            dp_write <= ap_valid & hwrite;
            dp_ctrl <= ap_valid & ap_ctrl;
        end
    end

    // ****************************************
    // unlock sequence
    // ****************************************
    always @* begin
        next_select = vector_select;
        next_change_enable = change_enable;
        next_window_count = window_count;
        next_tail_block = tail_block;
        next_pullup_disable = pullup_disable;
        next_debug_port_disable = debug_port_disable;
        if (change_enable) begin
            if (window_count == 3'h0) begin
                next_change_enable = 1'b0;
            end else begin
                next_window_count = window_count - 3'h1;
            end
        end
        if (tail_block && instr_done) begin
            next_tail_block = 1'b0;
        end
        if (wr_ctrl) begin
            next_pullup_disable = wd[`PULLUP_DISABLE_BIT];
            next_debug_port_disable = wd[`DEBUG_PORT_DISABLE_BIT];
            if (change_enable && !wd[`VECTOR_CHANGE_ENABLE_BIT]) begin
                next_select = wd[`VECTOR_SELECT_BIT];
                next_change_enable = 1'b0;
                next_window_count = 3'h0;
                next_tail_block = 1'b1;
            end else if (wd[`VECTOR_CHANGE_ENABLE_BIT]) begin
                next_change_enable = 1'b1;
                next_window_count = WINDOW_LOAD;
            end
            // otherwise the select bit keeps its value
        end
    end

    // ****************************************
    // placement calculation
    // ****************************************
    vector_address_calc #(
        .BOOT_START_SZ0(BOOT_START_SZ0),
        .BOOT_START_SZ1(BOOT_START_SZ1),
        .BOOT_START_SZ2(BOOT_START_SZ2),
        .BOOT_START_SZ3(BOOT_START_SZ3)
    ) u_lookup_calc (
        .boot_reset_fuse(fuse_boot_reset),
        .boot_size_fuses(fuse_boot_size),
        .vector_select(next_select),
        .vector_number(lookup_vector),
        .boot_start(boot_start),
        .reset_address(calc_reset),
        .vector_base(calc_base),
        .vector_address(calc_lookup)
    );

    vector_address_calc #(
        .BOOT_START_SZ0(BOOT_START_SZ0),
        .BOOT_START_SZ1(BOOT_START_SZ1),
        .BOOT_START_SZ2(BOOT_START_SZ2),
        .BOOT_START_SZ3(BOOT_START_SZ3)
    ) u_irq_calc (
        .boot_reset_fuse(fuse_boot_reset),
        .boot_size_fuses(fuse_boot_size),
        .vector_select(next_select),
        .vector_number(next_irq_vector),
        .boot_start(),
        .reset_address(),
        .vector_base(),
        .vector_address(calc_irq)
    );

    // ****************************************
    // interrupt source selection
    // ****************************************
    always @* begin
        next_req_any = 1'b1;
        next_irq_vector = 5'h00;
        if (analog_comp_req) begin
            next_irq_vector = `VEC_ANALOG_COMP;
        end else if (eeprom_ready_event) begin
            next_irq_vector = `VEC_EEPROM_READY;
        end else if (program_store_ready_event) begin
            next_irq_vector = `VEC_PROGRAM_STORE_READY;
        end else begin
            next_req_any = 1'b0;
        end
    end

    // ****************************************
    // interrupt blocking
    // ****************************************
    assign in_boot = (fetch_address >= boot_start);
    // lock bits are programmed when zero
    assign lock_block = (next_select & ~lock_app & ~in_boot) |
        (~next_select & ~lock_boot & in_boot);
    assign next_blocked = next_change_enable | next_tail_block |
        lock_block;
    // ****************************************
    // read data
    // ****************************************
    assign ctrl_read = {next_debug_port_disable, 2'b00,
        next_pullup_disable, 2'b00, next_select,
        next_change_enable};
    assign stat_read = {13'h0000, in_boot, next_change_enable,
        next_blocked, calc_reset};

    // ****************************************
    // registers
    // ****************************************
    always @(posedge clk_sys) begin
        if (srst) begin
            vector_select <= 1'b0;
            change_enable <= 1'b0;
            window_count <= 3'h0;
            tail_block <= 1'b0;
            pullup_disable <= 1'b0;
            debug_port_disable <= 1'b0;
            port_pullup_off <= {NUM_PORTS{1'b0}};
            fuse_boot_reset <= boot_reset_fuse;
            fuse_boot_size <= boot_size_fuses;
            lock_app <= app_side_boot_lock;
            lock_boot <= boot_side_boot_lock;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h00000000;
            reset_address <= `RESET_VECTOR_ADDR;
            vector_base <= `VECTOR_TABLE_BASE;
            lookup_address <= 16'h0000;
            irq_request <= 1'b0;
            irq_vector <= 5'h00;
            irq_address <= 16'h0000;
            irq_blocked <= 1'b0;
        end else begin
            vector_select <= next_select;
            change_enable <= next_change_enable;
            window_count <= next_window_count;
            tail_block <= next_tail_block;
            pullup_disable <= next_pullup_disable;
            debug_port_disable <= next_debug_port_disable;
            port_pullup_off <= {NUM_PORTS{next_pullup_disable}};
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (ap_valid && !hwrite && ap_ctrl) begin
                hrdata <= {24'h000000, ctrl_read};
            end else if (ap_valid && !hwrite && ap_stat) begin
                hrdata <= stat_read;
            end else begin
                hrdata <= 32'h00000000;
            end
            reset_address <= calc_reset;
            vector_base <= calc_base;
            lookup_address <= calc_lookup;
            irq_vector <= next_irq_vector;
            irq_address <= calc_irq;
            irq_blocked <= next_blocked;
            // the global flag is only read here, never written
            irq_request <= next_req_any & global_int_enable &
                ~next_blocked;
        end
    end

endmodule

// >>> verif/ivp_chk.sv
// checker for the interrupt vector placement block
// assumes a bind from the bench top onto the design
`timescale 1ns/1ps
module ivp_chk #(
    parameter NUM_PORTS = 3
) (
    // clock and reset
    input wire clk_sys,
    input wire srst,
    // bus and core inputs
    input wire [31:0] hwdata,
    input wire global_int_enable,
    input wire analog_comp_req,
    // block outputs
    input wire irq_request,
    input wire [4:0] irq_vector,
    input wire [15:0] irq_address,
    input wire irq_blocked,
    input wire vector_select,
    input wire [15:0] vector_base,
    input wire [15:0] reset_address,
    input wire pullup_disable,
    input wire [NUM_PORTS-1:0] port_pullup_off
);
default clocking cb @(posedge clk_sys);
endclocking
default disable iff (srst);
AST_PULLUP: assert property (
    port_pullup_off == {NUM_PORTS{pullup_disable}})
    else $error("pullup fan-out wrong");
AST_GIE: assert property (
    irq_request |-> $past(global_int_enable))
    else $error("request without global enable");
AST_PRIO: assert property (
    irq_request && $past(analog_comp_req) |-> irq_vector == 5'h1b)
    else $error("comparator vector wrong");
AST_ADDR: assert property (
    irq_request && $stable(vector_base) |->
    irq_address == vector_base + {10'h0, irq_vector - 5'h02, 1'b0})
    else $error("vector address wrong");
AST_BASE: assert property (
    !vector_select |-> vector_base == 16'h0002)
    else $error("base not at start of flash");
AST_SEL: assert property (
    $changed(vector_select) |-> $past(irq_blocked) && !hwdata[0])
    else $error("select changed outside window");
AST_BLK: assert property (
    $rose(irq_blocked) && $past(hwdata[0]) |-> irq_blocked[*3])
    else $error("block too short");
AST_RST: assert property (
    !$past(srst, 2) |-> $stable(reset_address))
    else $error("reset address moved");
endmodule

// >>> verif/core_model.sv
// core side model: fetch address and instruction completion
// assumes the bench sets the program counter level
`timescale 1ns/1ps
module core_model (
    // clock and reset
    input wire clk_sys,
    input wire srst,
    // program counter from the bench
    input wire [15:0] pc,
    // towards the block
    output reg [15:0] fetch_address,
    output reg instr_done
);
reg [1:0] phase;
always @(posedge clk_sys) begin
    if (srst) begin
        phase <= 2'h0;
        instr_done <= 1'b0;
        fetch_address <= 16'h0000;
    end else begin
        phase <= phase + 2'h1;
        instr_done <= (phase == 2'h3);
        fetch_address <= pc;
    end
end
endmodule

// >>> verif/interrupt_vector_placement_tb_top.sv
// bench top for the interrupt vector placement block
// assumes the checker and core model files are compiled first
`timescale 1ns/1ps
module interrupt_vector_placement_tb_top;
reg clk_sys = 1'b0;
reg srst = 1'b1;
reg hsel = 1'b0;
reg [31:0] haddr = 32'h0;
reg [1:0] htrans = 2'h0;
reg hwrite = 1'b0;
reg [31:0] hwdata = 32'h0;
reg boot_reset_fuse = 1'b1;
reg [1:0] boot_size_fuses = 2'h0;
reg app_side_boot_lock = 1'b1;
reg boot_side_boot_lock = 1'b1;
reg [15:0] pc = 16'h0;
reg global_int_enable = 1'b0;
reg [4:0] lookup_vector = 5'h1c;
reg [2:0] req = 3'h0;
wire hreadyout, hresp, instr_done, irq_request, irq_blocked;
wire vector_select, pullup_disable, debug_port_disable;
wire [31:0] hrdata;
wire [15:0] fetch_address, reset_address, vector_base;
wire [15:0] lookup_address, irq_address;
wire [4:0] irq_vector;
wire [2:0] port_pullup_off;
integer mismatches = 0;
integer checked = 0;
integer i;
reg [31:0] rdat;
// ****************
// clock and parts
// ****************
initial forever #2.5 clk_sys = ~clk_sys;
core_model core (.clk_sys(clk_sys), .srst(srst), .pc(pc),
    .fetch_address(fetch_address), .instr_done(instr_done));
interrupt_vector_placement uut (.clk_sys(clk_sys), .srst(srst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .boot_reset_fuse(boot_reset_fuse), .boot_size_fuses(boot_size_fuses),
    .app_side_boot_lock(app_side_boot_lock),
    .boot_side_boot_lock(boot_side_boot_lock),
    .fetch_address(fetch_address), .instr_done(instr_done),
    .global_int_enable(global_int_enable), .lookup_vector(lookup_vector),
    .analog_comp_req(req[2]), .eeprom_ready_event(req[1]),
    .program_store_ready_event(req[0]), .reset_address(reset_address),
    .vector_base(vector_base), .lookup_address(lookup_address),
    .irq_request(irq_request), .irq_vector(irq_vector),
    .irq_address(irq_address), .irq_blocked(irq_blocked),
    .vector_select(vector_select), .pullup_disable(pullup_disable),
    .port_pullup_off(port_pullup_off),
    .debug_port_disable(debug_port_disable));
// ****************
// tasks
// ****************
task chk(input [31:0] seen, input [31:0] exp);
    begin
        checked = checked + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("MISMATCH %0t seen %h want %h", $time, seen, exp);
        end
    end
endtask
task xfer(input w, input [31:0] a, input [31:0] d);
    begin
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        rdat = hrdata;
    end
endtask
task do_reset(input f, input [1:0] s, input l);
    begin
        srst <= 1'b1;
        boot_reset_fuse <= f;
        boot_size_fuses <= s;
        app_side_boot_lock <= l;
        repeat (2) @(posedge clk_sys);
        srst <= 1'b0;
        repeat (2) @(posedge clk_sys);
    end
endtask
task summarize;
    begin
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    end
endtask
// ****************
// tests
// ****************
initial begin
    #100000;
    mismatches = mismatches + 1;
    summarize;
end
initial begin
    do_reset(1'b1, 2'h0, 1'b1);
    xfer(1'b0, 32'h0, 32'h0);
    chk(rdat, 32'h0);
    xfer(1'b0, 32'h4, 32'h0);
    chk(rdat, 32'h0);
    chk({16'h0, vector_base}, 32'h2);
    xfer(1'b1, 32'h0, 32'hfe);
    xfer(1'b0, 32'h0, 32'h0);
    chk(rdat, 32'h90);
    chk({27'h0, pullup_disable, port_pullup_off, debug_port_disable},
        32'h1f);
    xfer(1'b1, 32'h0, 32'h1);
    #1;
    chk({31'h0, irq_blocked}, 32'h1);
    xfer(1'b1, 32'h0, 32'h2);
    #1;
    chk({31'h0, vector_select}, 32'h1);
    chk({16'h0, vector_base}, 32'h3802);
    xfer(1'b0, 32'h0, 32'h0);
    chk(rdat, 32'h2);
    global_int_enable <= 1'b1;
    for (i = 0; i < 3; i = i + 1) begin
        req <= 3'h7 >> i;
        repeat (6) @(posedge clk_sys);
        #1;
        chk({27'h0, irq_vector}, 27 + i);
        chk({16'h0, irq_address}, 32'h3802 + 2 * (25 + i));
    end
    chk({16'h0, lookup_address}, 32'h3836);
    global_int_enable <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk({31'h0, irq_request}, 32'h0);
    global_int_enable <= 1'b1;
    xfer(1'b1, 32'h0, 32'h1);
    #1;
    for (i = 0; i < 5; i = i + 1) begin
        chk({31'h0, irq_blocked}, i < 4);
        @(posedge clk_sys);
        #1;
    end
    chk({31'h0, irq_request}, 32'h1);
    xfer(1'b1, 32'h0, 32'h0);
    #1;
    chk({31'h0, vector_select}, 32'h1);
    do_reset(1'b0, 2'h3, 1'b0);
    #1;
    chk({16'h0, reset_address}, 32'h3f00);
    chk({16'h0, vector_base}, 32'h2);
    xfer(1'b1, 32'h0, 32'h1);
    xfer(1'b1, 32'h0, 32'h2);
    repeat (6) @(posedge clk_sys);
    #1;
    chk({31'h0, irq_blocked}, 32'h1);
    pc <= 16'h3f10;
    repeat (3) @(posedge clk_sys);
    #1;
    chk({31'h0, irq_blocked}, 32'h0);
    chk({16'h0, vector_base}, 32'h3f02);
    xfer(1'b0, 32'h4, 32'h0);
    chk(rdat, 32'h43f00);
    summarize;
end
endmodule
bind interrupt_vector_placement ivp_chk #(.NUM_PORTS(NUM_PORTS)) chk_i (
    .clk_sys(clk_sys), .srst(srst), .hwdata(hwdata),
    .global_int_enable(global_int_enable),
    .analog_comp_req(analog_comp_req), .irq_request(irq_request),
    .irq_vector(irq_vector), .irq_address(irq_address),
    .irq_blocked(irq_blocked), .vector_select(vector_select),
    .vector_base(vector_base), .reset_address(reset_address),
    .pullup_disable(pullup_disable), .port_pullup_off(port_pullup_off));
